// >>> include/isr_map.vh
`ifndef ISR_MAP_VH
`define ISR_MAP_VH

// Source identity registers
`define ISR_OFS_LEVEL_SRC 8'h14
`define ISR_OFS_MOD_SRC 8'h18
`define ISR_OFS_TMR0_SRC 8'h20
`define ISR_OFS_TMR1_SRC 8'h24
`define ISR_OFS_SER0_SRC 8'h30

// Event status, mask, pending and active line registers
`define ISR_OFS_EVT_STATUS 8'hA0
`define ISR_OFS_EVT_MASK 8'hA4
`define ISR_OFS_EVT_PEND 8'hA8
`define ISR_OFS_ACTIVE 8'hAC

// Source identity field
`define ISR_SRC_FLAG_BIT 0
`define ISR_SRC_FIELD_W 3

// Event status bit positions
`define ISR_EVT_LEVEL 0
`define ISR_EVT_MOD 1
`define ISR_EVT_TMR0 2
`define ISR_EVT_TMR1 3
`define ISR_EVT_SER0 4
`define ISR_EVT_RO_WRITE 5
`define ISR_EVT_UNMAPPED 6
`define ISR_EVT_W 7

// Line numbers reported by the active line register
`define ISR_LINE_LEVEL 5'h05
`define ISR_LINE_MOD 5'h06
`define ISR_LINE_TMR0 5'h08
`define ISR_LINE_TMR1 5'h09
`define ISR_LINE_SER0 5'h0C
`define ISR_ACTIVE_VALID_BIT 7

// Reset values
`define ISR_RST_MASK 7'h00
`define ISR_RST_STATUS 7'h00
`define ISR_RST_RDATA 32'h00000000

`endif

// >>> hw/isr_event_bit.v
module isr_event_bit (
    clk,
    rst_b,
    level_in,
    edge_mode,
    clear,
    sticky
);
    input wire clk;
    input wire rst_b;
    input wire level_in;
    input wire edge_mode;
    input wire clear;
    output reg sticky;

    reg level_q;
    wire set;

    // Edge mode catches a raise; level mode for one-cycle pulses
    assign set = edge_mode ? (level_in & ~level_q) : level_in;

    always @(posedge clk) begin
        if (!rst_b) begin
            level_q <= 1'b0;
            sticky <= 1'b0;
        end else begin
            level_q <= level_in;
            // Set wins over a clear in the same cycle
            if (set) begin
                sticky <= 1'b1;
            end else if (clear) begin
                sticky <= 1'b0;
            end
        end
    end
endmodule // isr_event_bit

// >>> hw/isr_regs.v
// Summary of operation
// - Read-only register at 0x14; bit 0 is level flag, bits 2:1 zero.
// - Read-only register at 0x18; bit 0 is modulator flag, bits 2:1 zero.
// - Read-only register at 0x20; bit 0 is timer zero flag, bits 2:1 zero.
// - Read-only register at 0x24; bit 0 is timer one flag, bits 2:1 zero.
// - Read-only register at 0x30; bit 0 is serial zero flag, bits 2:1 zero.

`include "isr_map.vh"

module isr_regs #(
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    output reg irq,
    input wire level_control_irq_flag,
    input wire modulator_irq_flag,
    input wire timer_zero_irq_flag,
    input wire timer_one_irq_flag,
    input wire serial_zero_irq_flag
);

    localparam EW = `ISR_EVT_W;
    // Width of the source identity field
    localparam FW = `ISR_SRC_FIELD_W;

    // Offsets sized to the address port for an exact compare
    localparam [ADDR_W-1:0] OFS_LEVEL = `ISR_OFS_LEVEL_SRC;
    localparam [ADDR_W-1:0] OFS_MOD = `ISR_OFS_MOD_SRC;
    localparam [ADDR_W-1:0] OFS_TMR0 = `ISR_OFS_TMR0_SRC;
    localparam [ADDR_W-1:0] OFS_TMR1 = `ISR_OFS_TMR1_SRC;
    localparam [ADDR_W-1:0] OFS_SER0 = `ISR_OFS_SER0_SRC;
    localparam [ADDR_W-1:0] OFS_STATUS = `ISR_OFS_EVT_STATUS;
    localparam [ADDR_W-1:0] OFS_MASK = `ISR_OFS_EVT_MASK;
    localparam [ADDR_W-1:0] OFS_PEND = `ISR_OFS_EVT_PEND;
    localparam [ADDR_W-1:0] OFS_ACTIVE = `ISR_OFS_ACTIVE;

    // Line numbers shown by the active line register
    localparam [4:0] LINE_LEVEL = `ISR_LINE_LEVEL;
    localparam [4:0] LINE_MOD = `ISR_LINE_MOD;
    localparam [4:0] LINE_TMR0 = `ISR_LINE_TMR0;
    localparam [4:0] LINE_TMR1 = `ISR_LINE_TMR1;
    localparam [4:0] LINE_SER0 = `ISR_LINE_SER0;

    // Address decode
    reg hit_level_src;
    reg hit_mod_src;
    reg hit_tmr0_src;
    reg hit_tmr1_src;
    reg hit_ser0_src;
    reg hit_status;
    reg hit_mask;
    reg hit_pend;
    reg hit_active;
    reg hit_any;
    reg hit_src;

    // Register state
    reg [EW-1:0] mask_q;
    reg [EW-1:0] mask_d;
    reg [31:0] rdata_d;
    reg irq_d;

    // Event bits
    wire [EW-1:0] status;
    wire [EW-1:0] clear_req;
    wire [EW-1:0] pend;
    wire ro_write_evt;
    wire unmapped_evt;
    wire status_wr;

    // Source identity fields
    wire [`ISR_SRC_FIELD_W-1:0] level_field;
    wire [`ISR_SRC_FIELD_W-1:0] mod_field;
    wire [`ISR_SRC_FIELD_W-1:0] tmr0_field;
    wire [`ISR_SRC_FIELD_W-1:0] tmr1_field;
    wire [`ISR_SRC_FIELD_W-1:0] ser0_field;

    // Full read words of the source registers
    wire [31:0] level_word;
    wire [31:0] mod_word;
    wire [31:0] tmr0_word;
    wire [31:0] tmr1_word;
    wire [31:0] ser0_word;

    // Read data of the two register groups
    reg [31:0] src_rdata;
    reg [31:0] ctl_rdata;

    // Bus decode terms
    wire src_wr;
    wire mask_wr;
    wire wr_unmapped;
    wire rd_unmapped;

    // Active line report
    reg [4:0] active_num;
    reg active_valid;

    // Source registers: full compare, so no alias hides a stray access
    always @* begin
        hit_level_src = 1'h0;
        hit_mod_src = 1'h0;
        hit_tmr0_src = 1'h0;
        hit_tmr1_src = 1'h0;
        hit_ser0_src = 1'h0;
        if (addr == OFS_LEVEL) begin
            hit_level_src = 1'h1;
        end else if (addr == OFS_MOD) begin
            hit_mod_src = 1'h1;
        end else if (addr == OFS_TMR0) begin
            hit_tmr0_src = 1'h1;
        end else if (addr == OFS_TMR1) begin
            hit_tmr1_src = 1'h1;
        end else if (addr == OFS_SER0) begin
            hit_ser0_src = 1'h1;
        end
    end

    // Event status, mask, pending and active line registers
    always @* begin
        hit_status = 1'h0;
        hit_mask = 1'h0;
        hit_pend = 1'h0;
        hit_active = 1'h0;
        if (addr == OFS_STATUS) begin
            hit_status = 1'h1;
        end else if (addr == OFS_MASK) begin
            hit_mask = 1'h1;
        end else if (addr == OFS_PEND) begin
            hit_pend = 1'h1;
        end else if (addr == OFS_ACTIVE) begin
            hit_active = 1'h1;
        end
    end

    // Any hit at all; a missed read or write is a bus fault
    always @* begin
        hit_src = hit_level_src | hit_mod_src | hit_tmr0_src |
            hit_tmr1_src | hit_ser0_src;
        hit_any = hit_src | hit_status | hit_mask | hit_pend |
            hit_active;
    end

    // Identity fields: flag in bit 0, upper field bits tied low
    assign level_field = {2'b00, level_control_irq_flag};
    assign mod_field = {2'b00, modulator_irq_flag};
    assign tmr0_field = {2'b00, timer_zero_irq_flag};
    assign tmr1_field = {2'b00, timer_one_irq_flag};
    assign ser0_field = {2'b00, serial_zero_irq_flag};

    // Reserved bits above the field read zero
    assign level_word = {{(32-FW){1'h0}}, level_field};
    assign mod_word = {{(32-FW){1'h0}}, mod_field};
    assign tmr0_word = {{(32-FW){1'h0}}, tmr0_field};
    assign tmr1_word = {{(32-FW){1'h0}}, tmr1_field};
    assign ser0_word = {{(32-FW){1'h0}}, ser0_field};

    // A write aimed at a source register is dropped and only reported
    assign src_wr = wr_en & hit_src;
    assign ro_write_evt = src_wr;
    assign mask_wr = wr_en & hit_mask;
    assign wr_unmapped = wr_en & ~hit_any;
    assign rd_unmapped = rd_en & ~hit_any;
    assign unmapped_evt = wr_unmapped | rd_unmapped;
    // A clear and a raise in one cycle: the raise wins inside the bit
    assign status_wr = wr_en & hit_status;
    assign clear_req = status_wr ? wdata[EW-1:0] : {EW{1'b0}};

    // Peripheral flags are levels; catch each raise once
    isr_event_bit u_evt_level (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(level_control_irq_flag),
        .edge_mode(1'b1),
        .clear(clear_req[`ISR_EVT_LEVEL]),
        .sticky(status[`ISR_EVT_LEVEL])
    );

    isr_event_bit u_evt_mod (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(modulator_irq_flag),
        .edge_mode(1'b1),
        .clear(clear_req[`ISR_EVT_MOD]),
        .sticky(status[`ISR_EVT_MOD])
    );

    isr_event_bit u_evt_tmr0 (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(timer_zero_irq_flag),
        .edge_mode(1'b1),
        .clear(clear_req[`ISR_EVT_TMR0]),
        .sticky(status[`ISR_EVT_TMR0])
    );

    isr_event_bit u_evt_tmr1 (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(timer_one_irq_flag),
        .edge_mode(1'b1),
        .clear(clear_req[`ISR_EVT_TMR1]),
        .sticky(status[`ISR_EVT_TMR1])
    );

    isr_event_bit u_evt_ser0 (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(serial_zero_irq_flag),
        .edge_mode(1'b1),
        .clear(clear_req[`ISR_EVT_SER0]),
        .sticky(status[`ISR_EVT_SER0])
    );

    // Bus faults are single-cycle pulses, so no edge detect
    isr_event_bit u_evt_ro_write (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(ro_write_evt),
        .edge_mode(1'b0),
        .clear(clear_req[`ISR_EVT_RO_WRITE]),
        .sticky(status[`ISR_EVT_RO_WRITE])
    );

    isr_event_bit u_evt_unmapped (
        .clk(clk),
        .rst_b(rst_b),
        .level_in(unmapped_evt),
        .edge_mode(1'b0),
        .clear(clear_req[`ISR_EVT_UNMAPPED]),
        .sticky(status[`ISR_EVT_UNMAPPED])
    );

    // Pending is what the mask lets through
    assign pend = status & mask_q;

    // Lowest numbered pending line wins; bus faults are not lines
    always @* begin
        active_valid = 1'b1;
        active_num = 5'h00;
        if (pend[`ISR_EVT_LEVEL]) begin
            active_num = LINE_LEVEL;
        end else if (pend[`ISR_EVT_MOD]) begin
            active_num = LINE_MOD;
        end else if (pend[`ISR_EVT_TMR0]) begin
            active_num = LINE_TMR0;
        end else if (pend[`ISR_EVT_TMR1]) begin
            active_num = LINE_TMR1;
        end else if (pend[`ISR_EVT_SER0]) begin
            active_num = LINE_SER0;
        end else begin
            active_valid = 1'b0;
        end
    end

    // Mask is the only plain read-write register
    always @* begin
        mask_d = mask_q;
        if (mask_wr) begin
            mask_d = wdata[EW-1:0];
        end
    end

    // Source group; the flag is taken as it stands with the strobe
    always @* begin
        src_rdata = `ISR_RST_RDATA;
        if (hit_level_src) begin
            src_rdata = level_word;
        end else if (hit_mod_src) begin
            src_rdata = mod_word;
        end else if (hit_tmr0_src) begin
            src_rdata = tmr0_word;
        end else if (hit_tmr1_src) begin
            src_rdata = tmr1_word;
        end else if (hit_ser0_src) begin
            src_rdata = ser0_word;
        end
    end

    // Control group; pending and active line are derived, not stored
    always @* begin
        ctl_rdata = `ISR_RST_RDATA;
        if (hit_status) begin
            ctl_rdata = {25'h0000000, status};
        end else if (hit_mask) begin
            ctl_rdata = {25'h0000000, mask_q};
        end else if (hit_pend) begin
            ctl_rdata = {25'h0000000, pend};
        end else if (hit_active) begin
            ctl_rdata = {24'h000000, active_valid, 2'h0, active_num};
        end
    end

    // The groups never hit together, so an OR merges them
    always @* begin
        rdata_d = `ISR_RST_RDATA;
        if (rd_en) begin
            rdata_d = src_rdata | ctl_rdata;
        end
    end

    // Interrupt follows the pending set one cycle later
    always @* begin
        irq_d = |pend;
    end

    // Mask resets closed so nothing interrupts before software opts in
    always @(posedge clk) begin
        if (!rst_b) begin
            mask_q <= `ISR_RST_MASK;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Read data stands one cycle, then drops back to zero
    always @(posedge clk) begin
        if (!rst_b) begin
            rdata <= `ISR_RST_RDATA;
        end else begin
            rdata <= rdata_d;
        end
    end

    // Registered so a decode glitch never reaches the pin
    always @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'h0;
        end else begin
            irq <= irq_d;
        end
    end

endmodule // isr_regs

// >>> bench/isr_regs_chk.sv
`include "isr_map.vh"

module isr_regs_chk #(
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rdata,
    input wire irq,
    input wire level_control_irq_flag,
    input wire modulator_irq_flag,
    input wire timer_zero_irq_flag,
    input wire timer_one_irq_flag,
    input wire serial_zero_irq_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire src_hit = addr == `ISR_OFS_LEVEL_SRC || addr == `ISR_OFS_MOD_SRC ||
        addr == `ISR_OFS_TMR0_SRC || addr == `ISR_OFS_TMR1_SRC ||
        addr == `ISR_OFS_SER0_SRC;
    chk_level_src: assert property (
        rd_en && addr == `ISR_OFS_LEVEL_SRC |=>
        rdata == {31'h0, $past(level_control_irq_flag)})
        else $error("level source read wrong");
    chk_mod_src: assert property (
        rd_en && addr == `ISR_OFS_MOD_SRC |=>
        rdata == {31'h0, $past(modulator_irq_flag)})
        else $error("modulator source read wrong");
    chk_tmr0_src: assert property (
        rd_en && addr == `ISR_OFS_TMR0_SRC |=>
        rdata == {31'h0, $past(timer_zero_irq_flag)})
        else $error("timer zero source read wrong");
    chk_tmr1_src: assert property (
        rd_en && addr == `ISR_OFS_TMR1_SRC |=>
        rdata == {31'h0, $past(timer_one_irq_flag)})
        else $error("timer one source read wrong");
    chk_ser0_src: assert property (
        rd_en && addr == `ISR_OFS_SER0_SRC |=>
        rdata == {31'h0, $past(serial_zero_irq_flag)})
        else $error("serial zero source read wrong");
    chk_reserved_zero: assert property (
        rd_en && src_hit |=> rdata[31:3] == 29'h0)
        else $error("reserved source bits not zero");
    chk_rdata_idle: assert property (
        !rd_en |=> rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule // isr_regs_chk

bind isr_regs isr_regs_chk #(.ADDR_W(ADDR_W)) u_isr_regs_chk (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .level_control_irq_flag(level_control_irq_flag),
    .modulator_irq_flag(modulator_irq_flag),
    .timer_zero_irq_flag(timer_zero_irq_flag),
    .timer_one_irq_flag(timer_one_irq_flag),
    .serial_zero_irq_flag(serial_zero_irq_flag));

// >>> bench/isr_periph_model.sv
module isr_periph_model (
    input wire clk,
    input wire [4:0] want,
    output logic [4:0] flags = 5'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // Flags move only after an edge, as a peripheral's own register would
    always @(posedge clk) begin
        flags <= want;
    end
endmodule // isr_periph_model

// >>> bench/isr_regs_bench.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s exp %h got %h", nm, e, g); end end

module isr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0;
    logic rst_b = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 0;
    logic rd_en = 0;
    logic [4:0] want = 5'h00;
    wire [4:0] flags;
    wire [31:0] rdata;
    wire irq;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] ofs [5] = '{8'h14, 8'h18, 8'h20, 8'h24, 8'h30};

    isr_periph_model u_isr_periph_model (.clk(clk), .want(want),
        .flags(flags));
    isr_regs #(.ADDR_W(8)) u_isr_regs (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .irq(irq), .level_control_irq_flag(flags[0]),
        .modulator_irq_flag(flags[1]), .timer_zero_irq_flag(flags[2]),
        .timer_one_irq_flag(flags[3]), .serial_zero_irq_flag(flags[4]));

    initial begin
        forever #20 clk = ~clk;
    end

    task results;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Identity word: the line's flag in bit 0, all else zero
    function automatic logic [31:0] src_exp(input logic [4:0] f,
        input int j);
        return {31'h0, f[j]};
    endfunction

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1;
        @(posedge clk);
        wr_en <= 0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1;
        @(posedge clk);
        rd_en <= 0;
        #1;
        `CHK("rdata", e, rdata)
    endtask

    // The design lags a flag by two edges, so settle before judging
    task flag_set(input logic [4:0] v);
        @(posedge clk);
        want <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        void'($urandom(10546));
        repeat (8) @(posedge clk);
        rst_b <= 1;
        for (int i = 0; i < 30; i++) begin
            flag_set(i == 0 ? 5'h1F : i == 1 ? 5'h00 : 5'($urandom));
            for (int j = 0; j < 5; j++) begin
                wr(ofs[j], i == 0 ? 32'hFFFFFFFF : $urandom);
                rd(ofs[j], src_exp(want, j));
            end
        end
        flag_set(5'h00);
        wr(8'hA0, 32'h0000007F);
        rd(8'hA0, 32'h0);
        wr(8'hA4, 32'h00000020);
        wr(8'h14, 32'hFFFFFFFF);
        flag_set(5'h00);
        `CHK("irq", 1'b1, irq)
        rd(8'hA8, 32'h00000020);
        rd(8'h14, 32'h0);
        wr(8'hA4, 32'h00000044);
        flag_set(5'h00);
        `CHK("irq", 1'b0, irq)
        wr(8'hA0, 32'h00000020);
        rd(8'h40, 32'h0);
        rd(8'hA0, 32'h00000040);
        wr(8'hA0, 32'h00000040);
        flag_set(5'h04);
        `CHK("irq", 1'b1, irq)
        rd(8'hA0, 32'h00000004);
        rd(8'hAC, 32'h00000088);
        rd(8'h20, 32'h00000001);
        results();
    end
endmodule // isr_regs_bench
